// ---- logic/etc_timer.v ----
// Timer channel control with Avalon-MM slave, 10-bit counter and two channels.
// Assumes one clock, async active-low reset, capture pins asynchronous.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "etc_map.vh"
module etc_timer #(
  parameter CNT_W = 10
) (
  // Clock and reset
  input wire mclk_in,
  input wire arst_n_in,
  // Avalon-MM slave
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  // Capture pins
  input wire channel_a_capture_pin_in,
  input wire channel_b_capture_pin_in,
  // Output pins
  output wire channel_a_output_pin_out,
  output wire channel_a_output_pin_oe_n_out,
  output wire channel_b_output_pin_out,
  output wire channel_b_output_pin_oe_n_out
);
  reg [7:0] ctrl0_q;
  reg [7:0] cha_q;
  reg [7:0] chb_q;
  reg [CNT_W-1:0] cmpa_q;
  reg [CNT_W-1:0] cmpb_q;
  reg [CNT_W-1:0] capt_q;
  reg [CNT_W-1:0] cnt_q;
  reg dir_q;
  reg on_q;
  reg done_q;
  reg pulse_a_q;
  reg pulse_b_q;
  reg cap_a_q;
  reg cap_b_q;
  wire cap_a_s;
  wire cap_b_s;
  wire on_bit = ctrl0_q[`ETC_C0_ON];
  // Edge of the on bit: holding it high restarts nothing
  wire on_rise = on_bit & ~on_q;
  wire run = on_bit & ~ctrl0_q[`ETC_C0_PAUSE];
  wire [1:0] mode_a = cha_q[`ETC_MODE_HI:`ETC_MODE_LO];
  wire [1:0] mode_b = chb_q[`ETC_MODE_HI:`ETC_MODE_LO];
  wire [1:0] align = chb_q[`ETC_ALIGN_HI:`ETC_ALIGN_LO];
  wire [2:0] period = ctrl0_q[`ETC_C0_PER_HI:`ETC_C0_PER_LO];
  wire clr_sel = cha_q[`ETC_CLRSEL];
  wire is_pwm = (mode_a == `ETC_MODE_PWM);
  wire is_cap = (mode_a == `ETC_MODE_CAP);
  wire match_a = run && (cnt_q == cmpa_q);
  wire match_b = run && (cnt_q == cmpb_q);
  wire per_lo_zero = (cnt_q[CNT_W-4:0] == {(CNT_W-3){1'b0}});
  wire match_p = run && (period != 3'h0) && (cnt_q[CNT_W-1:CNT_W-3] == period) && per_lo_zero;
  wire ovf = run && (cnt_q == {CNT_W{1'b1}});
  wire pwm_edge = (align == 2'h0);
  // PWM period comes from the period bits; clear select has no say here
  wire [CNT_W-1:0] ptop = (period == 3'h0) ? {CNT_W{1'b1}} : {period, {(CNT_W-3){1'b0}}} - 1'b1;
  wire [CNT_W-1:0] pwm_top = ptop;
  wire end_of_period = run && (cnt_q == pwm_top);
  // Compare/timer clear source
  wire cmp_clear = clr_sel ? match_a : (match_p | (ovf && period == 3'h0));
  // Next-state values
  reg [CNT_W-1:0] cnt_d;
  reg dir_d;
  reg cap_en_a;
  reg cap_en_b;

  // Edge qualify for capture, shared by both channels
  function cap_hit;
    input [1:0] sel;
    input now;
    input prev;
    begin
      case (sel)
        2'h0: cap_hit = now & ~prev;
        2'h1: cap_hit = ~now & prev;
        2'h2: cap_hit = now ^ prev;
        default: cap_hit = 1'b0;
      endcase
    end
  endfunction

  // Centre modes with align 1 or 2 qualify the duty window with the count direction; align 3 ignores it
  function pwm_on;
    input [CNT_W-1:0] duty;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] top;
    input [1:0] al;
    input down;
    begin
      // Duty at or above period gives 100 %
      if (duty > top)
        pwm_on = 1'b1;
      else begin
        case (al)
          2'h1: pwm_on = !down && (cnt < duty);
          2'h2: pwm_on = down && (cnt < duty);
          default: pwm_on = (cnt < duty);
        endcase
      end
    end
  endfunction

  // Zero-extends a counter-wide value to a bus word
  function [31:0] rd_word;
    input [CNT_W-1:0] v;
    begin
      rd_word = {{(32-CNT_W){1'b0}}, v};
    end
  endfunction

  // Capture pins come from outside; two flops before any edge logic
  etc_sync2 u_sync_a (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .pin_in(channel_a_capture_pin_in),
    .sync_out(cap_a_s)
  );
  etc_sync2 u_sync_b (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .pin_in(channel_b_capture_pin_in),
    .sync_out(cap_b_s)
  );

  // Counter and direction
  always @* begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (on_rise) begin
      cnt_d = {CNT_W{1'b0}};
      dir_d = 1'b0;
    end else if (run) begin
      if (is_pwm && !pwm_edge) begin
        // Centre aligned counts up then down; clear select ignored here
        if (!dir_q && cnt_q == pwm_top)
          dir_d = 1'b1;
        else if (dir_q && cnt_q == {CNT_W{1'b0}})
          dir_d = 1'b0;
        if (dir_d)
          cnt_d = cnt_q - 1'b1;
        else
          cnt_d = cnt_q + 1'b1;
      end else if (is_pwm) begin
        cnt_d = end_of_period ? {CNT_W{1'b0}} : cnt_q + 1'b1;
        dir_d = 1'b0;
      end else if (is_cap) begin
        cnt_d = (ovf || match_p) ? {CNT_W{1'b0}} : cnt_q + 1'b1;
        dir_d = 1'b0;
      end else begin
        cnt_d = cmp_clear ? {CNT_W{1'b0}} : cnt_q + 1'b1;
        dir_d = 1'b0;
      end
    end
  end

  always @* begin
    cap_en_a = (mode_a == `ETC_MODE_CAP) && run && cap_hit(cha_q[`ETC_PF_HI:`ETC_PF_LO], cap_a_s, cap_a_q);
    cap_en_b = (mode_b == `ETC_MODE_CAP) && run && cap_hit(chb_q[`ETC_PF_HI:`ETC_PF_LO], cap_b_s, cap_b_q);
  end

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= {CNT_W{1'b0}};
      dir_q <= 1'b0;
      on_q <= 1'b0;
      cap_a_q <= 1'b0;
      cap_b_q <= 1'b0;
      capt_q <= {CNT_W{1'b0}};
      pulse_a_q <= 1'b0;
      pulse_b_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      on_q <= on_bit;
      cap_a_q <= cap_a_s;
      cap_b_q <= cap_b_s;
      // One capture register for both channels; A wins a tie
      if (cap_en_a)
        capt_q <= cnt_q;
      else if (cap_en_b)
        capt_q <= cnt_q;
      // Single pulse: starts at on rise, ends at its compare match or at the end of the period
      if (on_rise) begin
        pulse_a_q <= 1'b1;
        pulse_b_q <= 1'b1;
        done_q <= 1'b0;
      end else begin
        if (match_a)
          pulse_a_q <= 1'b0;
        if (match_b)
          pulse_b_q <= 1'b0;
        if (end_of_period)
          done_q <= 1'b1;
      end
    end
  end

  etc_chan_out u_out_a (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .mode_in(mode_a),
    .pin_func_in(cha_q[`ETC_PF_HI:`ETC_PF_LO]),
    .level_in(cha_q[`ETC_LEVEL]),
    .invert_in(cha_q[`ETC_INV]),
    .on_rise_in(on_rise),
    .match_in(match_a),
    .pwm_active_in(run && pwm_on(cmpa_q, cnt_q, pwm_top, align, dir_q)),
    .pulse_active_in(pulse_a_q && !done_q && run),
    .pin_out(channel_a_output_pin_out),
    .pin_oe_n_out(channel_a_output_pin_oe_n_out)
  );
  etc_chan_out u_out_b (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .mode_in(mode_b),
    .pin_func_in(chb_q[`ETC_PF_HI:`ETC_PF_LO]),
    .level_in(chb_q[`ETC_LEVEL]),
    .invert_in(chb_q[`ETC_INV]),
    .on_rise_in(on_rise),
    .match_in(match_b),
    .pwm_active_in(run && pwm_on(cmpb_q, cnt_q, pwm_top, align, dir_q)),
    .pulse_active_in(pulse_b_q && !done_q && run),
    .pin_out(channel_b_output_pin_out),
    .pin_oe_n_out(channel_b_output_pin_oe_n_out)
  );

  // Avalon slave: one wait cycle per access, then answer
  wire req = avs_read_in | avs_write_in;
  // Mirrors waitrequest; both fall for one cycle per access
  reg done_ack_n;
  wire ack = req & avs_waitrequest_out & done_ack_n;
  reg [31:0] rd;
  always @* begin
    rd = 32'h0000_0000;
    case (avs_address_in)
      {1'b0, `ETC_ADDR_CTRL0}: rd = {24'h000000, ctrl0_q};
      {1'b0, `ETC_ADDR_CHA}: rd = {24'h000000, cha_q[7:2], dir_q, cha_q[0]};
      {1'b0, `ETC_ADDR_CHB}: rd = {24'h000000, chb_q};
      {1'b0, `ETC_ADDR_CMPA}: rd = rd_word(cmpa_q);
      {1'b1, `ETC_ADDR_CMPB}: rd = rd_word(cmpb_q);
      {1'b1, `ETC_ADDR_COUNT}: rd = rd_word(cnt_q);
      {1'b1, `ETC_ADDR_CAPT}: rd = rd_word(capt_q);
      default: rd = 32'h0000_0000;
    endcase
  end
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
      done_ack_n <= 1'b1;
      ctrl0_q <= `ETC_RST_CTRL;
      cha_q <= `ETC_RST_CTRL;
      chb_q <= `ETC_RST_CTRL;
      cmpa_q <= `ETC_RST_CMP;
      cmpb_q <= `ETC_RST_CMP;
    end else begin
      avs_waitrequest_out <= ~ack;
      done_ack_n <= ~ack;
      if (ack && avs_read_in)
        avs_readdata_out <= rd;
      // Writes land where the master samples waitrequest low
      if (avs_write_in && !avs_waitrequest_out) begin
        case (avs_address_in)
          {1'b0, `ETC_ADDR_CTRL0}: ctrl0_q <= avs_writedata_in[7:0];
          {1'b0, `ETC_ADDR_CHA}: cha_q <= {avs_writedata_in[7:2], 1'b0, avs_writedata_in[0]};
          {1'b0, `ETC_ADDR_CHB}: chb_q <= avs_writedata_in[7:0];
          {1'b0, `ETC_ADDR_CMPA}: cmpa_q <= avs_writedata_in[CNT_W-1:0];
          {1'b1, `ETC_ADDR_CMPB}: cmpb_q <= avs_writedata_in[CNT_W-1:0];
          // Counter and capture are read-only; writes to them drop
          default: ;
        endcase
      end
    end
  end
endmodule // etc_timer

// ---- logic/etc_map.vh ----
// Register map, field positions and reset values of the timer channel control block.
// Included by the design files of the block; definitions only.
`ifndef ETC_MAP_VH
`define ETC_MAP_VH
// Word byte addresses on the Avalon-MM slave
`define ETC_ADDR_CTRL0 4'h0
`define ETC_ADDR_CHA 4'h4
`define ETC_ADDR_CHB 4'h8
`define ETC_ADDR_CMPA 4'hC
// Second page, upper address bit set
`define ETC_ADDR_CMPB 4'h0
`define ETC_ADDR_COUNT 4'h4
`define ETC_ADDR_CAPT 4'h8
// Control 0 fields
`define ETC_C0_ON 3
`define ETC_C0_PAUSE 7
`define ETC_C0_PER_HI 2
`define ETC_C0_PER_LO 0
// Alignment field of the channel B control
`define ETC_ALIGN_HI 1
`define ETC_ALIGN_LO 0
// Channel control fields
`define ETC_MODE_HI 7
`define ETC_MODE_LO 6
`define ETC_PF_HI 5
`define ETC_PF_LO 4
`define ETC_LEVEL 3
`define ETC_INV 2
`define ETC_DIR 1
`define ETC_CLRSEL 0
// Modes
`define ETC_MODE_CMP 2'h0
`define ETC_MODE_CAP 2'h1
`define ETC_MODE_PWM 2'h2
`define ETC_MODE_TMR 2'h3
// Reset values and counter top
`define ETC_RST_CTRL 8'h00
`define ETC_RST_CMP 10'h000
`define ETC_TOP 10'h3FF
`endif

// ---- logic/etc_sync2.v ----
// Two-flop synchroniser for one asynchronous pin.
// Assumes the pin is unrelated to mclk_in.
`timescale 1ns/100ps
module etc_sync2 (
  // Clock and reset
  input wire mclk_in,
  input wire arst_n_in,
  // Pin and result
  input wire pin_in,
  output reg sync_out
);
  reg meta_q;
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule // etc_sync2

// ---- logic/etc_chan_out.v ----
// Output pin logic for one compare/PWM channel.
// Assumes match pulses and counter state come from the timer core on mclk_in.
`timescale 1ns/100ps
`include "etc_map.vh"
module etc_chan_out (
  // Clock and reset
  input wire mclk_in,
  input wire arst_n_in,
  // Configuration
  input wire [1:0] mode_in,
  input wire [1:0] pin_func_in,
  input wire level_in,
  input wire invert_in,
  // Timer events
  input wire on_rise_in,
  input wire match_in,
  input wire pwm_active_in,
  input wire pulse_active_in,
  // Pin
  output reg pin_out,
  output reg pin_oe_n_out
);
  reg state_q;
  reg state_d;
  reg lvl;
  always @* begin
    state_d = state_q;
    lvl = state_q;
    case (mode_in)
      `ETC_MODE_CMP: begin
        if (on_rise_in)
          state_d = level_in;
        else if (match_in) begin
          // Requested level equal to present level gives no visible change
          case (pin_func_in)
            2'h1: state_d = 1'b0;
            2'h2: state_d = 1'b1;
            2'h3: state_d = ~state_q;
            default: state_d = state_q;
          endcase
        end
        lvl = state_d;
      end
      `ETC_MODE_PWM: begin
        case (pin_func_in)
          2'h0: lvl = ~level_in;
          2'h1: lvl = level_in;
          2'h2: lvl = pwm_active_in ? level_in : ~level_in;
          default: lvl = pulse_active_in ? level_in : ~level_in;
        endcase
      end
      default: lvl = 1'b0;
    endcase
  end
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= 1'b0;
      pin_out <= 1'b0;
      pin_oe_n_out <= 1'b1;
    end else begin
      state_q <= state_d;
      // Timer/counter and capture release the pin; level unused, invert unused in timer/counter only
      pin_oe_n_out <= (mode_in == `ETC_MODE_TMR) || (mode_in == `ETC_MODE_CAP);
      pin_out <= lvl ^ (invert_in && mode_in != `ETC_MODE_TMR);
    end
  end
endmodule // etc_chan_out

// ---- sim/etc_pin_model.sv ----
// Far-side model: the two capture input pins of the timer block.
// Pins are plain levels, changed just after mclk_in edges.
`timescale 1ns/100ps
module etc_pin_model (
  // Clock
  input wire mclk_in,
  // Capture pins
  output reg cap_a_out,
  output reg cap_b_out
);
  initial begin
    cap_a_out = 1'b0;
    cap_b_out = 1'b0;
  end
  // Lag lets a scenario answer promptly or late
  task automatic drive(input bit ch, input bit v, input int lag);
    repeat (lag + 1) @(posedge mclk_in);
    if (ch) cap_b_out <= v;
    else cap_a_out <= v;
  endtask
endmodule // etc_pin_model

// ---- sim/etc_timer_monitor.sv ----
// Checker for the timer channel control block, bound to its top.
// Shadows control writes, so it knows each channel's mode.
`timescale 1ns/100ps
module etc_timer_monitor #(
  parameter CNT_W = 10
) (
  // Clock and reset
  input wire mclk_in,
  input wire arst_n_in,
  // Bus
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire avs_waitrequest_out,
  // Pins
  input wire channel_a_output_pin_out,
  input wire channel_a_output_pin_oe_n_out,
  input wire channel_b_output_pin_out,
  input wire channel_b_output_pin_oe_n_out
);
  reg [7:0] sa_q, sb_q, sa_p, sb_p;
  reg [1:0] up_q;
  reg on_q;
  wire wr = avs_write_in && !avs_waitrequest_out;
  // Pins lag a write by a register stage
  wire sta = &up_q && sa_q == sa_p;
  wire stb = &up_q && sb_q == sb_p;
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sa_q <= 8'h00;
      sb_q <= 8'h00;
      sa_p <= 8'h00;
      sb_p <= 8'h00;
      up_q <= 2'h0;
      on_q <= 1'b0;
    end else begin
      sa_p <= sa_q;
      sb_p <= sb_q;
      if (!(&up_q)) up_q <= up_q + 2'h1;
      if (wr && avs_address_in == 5'h04) sa_q <= avs_writedata_in[7:0];
      if (wr && avs_address_in == 5'h08) sb_q <= avs_writedata_in[7:0];
      if (wr && avs_address_in == 5'h00) on_q <= avs_writedata_in[3];
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  a_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low too long");
  a_tmr_release_a: assert property (sta && sa_q[7:6] == 2'h3 |-> channel_a_output_pin_oe_n_out)
    else $error("pin a driven in timer mode");
  a_tmr_release_b: assert property (stb && sb_q[7:6] == 2'h3 |-> channel_b_output_pin_oe_n_out)
    else $error("pin b driven in timer mode");
  a_cap_release_a: assert property (sta && sa_q[7:6] == 2'h1 |-> channel_a_output_pin_oe_n_out)
    else $error("pin a driven in capture mode");
  a_drive_cmp_b: assert property (stb && sb_q[7:6] == 2'h0 |-> !channel_b_output_pin_oe_n_out)
    else $error("pin b not driven in compare mode");
  a_init_level_a: assert property ($rose(on_q) && sa_q[7:6] == 2'h0 |->
    ##[1:4] channel_a_output_pin_out == (sa_q[3] ^ sa_q[2]))
    else $error("pin a not at initial level");
  a_pwm_force_a: assert property (sta && sa_q[7:5] == 3'h4 |->
    channel_a_output_pin_out == ((sa_q[4] ~^ sa_q[3]) ^ sa_q[2]))
    else $error("pin a forced level wrong");
  a_pwm_force_b: assert property (stb && sb_q[7:5] == 3'h4 |->
    channel_b_output_pin_out == ((sb_q[4] ~^ sb_q[3]) ^ sb_q[2]))
    else $error("pin b forced level wrong");
  a_hold_a: assert property (sta && sa_q == $past(sa_q, 2) && sa_q[7:4] == 4'h0 && on_q && $past(on_q)
    && $past(on_q, 2) && $past(on_q, 3) |-> $stable(channel_a_output_pin_out))
    else $error("pin a moved with no action");
endmodule // etc_timer_monitor

// ---- sim/tb.sv ----
// Self-checking bench for the timer channel control block.
// Drives the Avalon-MM slave and the pin model from mclk_in.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb;
  reg mclk_in, arst_n_in, avs_read_in, avs_write_in;
  reg [4:0] avs_address_in;
  reg [31:0] avs_writedata_in, q;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, cap_a, cap_b, pa, pa_oe_n, pb, pb_oe_n;
  int n_errors = 0;
  int num_checks = 0;
  etc_timer uut (.mclk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .channel_a_capture_pin_in(cap_a), .channel_b_capture_pin_in(cap_b),
    .channel_a_output_pin_out(pa), .channel_a_output_pin_oe_n_out(pa_oe_n),
    .channel_b_output_pin_out(pb), .channel_b_output_pin_oe_n_out(pb_oe_n));
  etc_pin_model pm (.mclk_in, .cap_a_out(cap_a), .cap_b_out(cap_b));
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  task automatic acc(input bit w, input [4:0] a, input [7:0] d);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic wr(input [4:0] a, input [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rk(input [4:0] a, input [31:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  task t_regs;
    rk(5'h04, 32'h0);
    rk(5'h08, 32'h0);
    wr(5'h1C, 8'hFF);
    rk(5'h1C, 32'h0);
    wr(5'h04, 8'hFF);
    rk(5'h04, 32'hFD);
    wr(5'h08, 8'hFF);
    rk(5'h08, 32'hFF);
    `CHK({pa_oe_n, pb_oe_n}, 2'b11)
  endtask
  task automatic t_cmp(input [7:0] c, input ia, input fa);
    wr(5'h00, 8'h00);
    wr(5'h04, c);
    wr(5'h08, c);
    wr(5'h00, 8'h09);
    repeat (3) @(posedge mclk_in);
    `CHK({pa, pb, pa_oe_n}, {ia, ia, 1'b0})
    repeat (50) @(posedge mclk_in);
    `CHK({pa, pb}, {fa, ia})
    repeat (45) @(posedge mclk_in);
    `CHK({pa, pb}, {fa, fa})
  endtask
  task automatic scan(input int n, output int mx, output bit wrap);
    int p;
    mx = 0;
    wrap = 0;
    p = 0;
    repeat (n) begin
      acc(1'b0, 5'h14, 8'h00);
      if (q < p) wrap = 1;
      p = q;
      if (q > mx) mx = q;
    end
  endtask
  task automatic t_clr;
    int mx;
    bit w;
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h01);
    wr(5'h00, 8'h08);
    scan(60, mx, w);
    `CHK(mx >= 36 && mx <= 41 && w, 1'b1)
    wr(5'h04, 8'h00);
    wr(5'h00, 8'h09);
    scan(90, mx, w);
    `CHK(mx >= 124 && mx <= 128 && w, 1'b1)
    wr(5'h00, 8'h08);
    scan(420, mx, w);
    `CHK(mx > 1015 && w, 1'b1)
    wr(5'h00, 8'h00);
    acc(1'b0, 5'h14, 8'h00);
    mx = q;
    repeat (9) @(posedge mclk_in);
    rk(5'h14, mx);
    wr(5'h00, 8'h08);
    acc(1'b0, 5'h14, 8'h00);
    `CHK(q < 8, 1'b1)
  endtask
  task automatic t_cap;
    reg [31:0] c;
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h70);
    wr(5'h08, 8'h70);
    wr(5'h00, 8'h08);
    pm.drive(1'b0, 1'b1, 5);
    pm.drive(1'b0, 1'b0, 5);
    rk(5'h18, 32'h0);
    `CHK({pa_oe_n, pb_oe_n}, 2'b11)
    for (int k = 0; k < 3; k++) begin
      wr(5'h04, {2'b01, k[1:0], 4'h0});
      acc(1'b0, 5'h18, 8'h00);
      c = q;
      pm.drive(1'b0, 1'b1, k);
      repeat (6) @(posedge mclk_in);
      acc(1'b0, 5'h18, 8'h00);
      `CHK(q != c, k != 1)
      c = q;
      pm.drive(1'b0, 1'b0, 2);
      repeat (6) @(posedge mclk_in);
      acc(1'b0, 5'h18, 8'h00);
      `CHK(q != c, k != 0)
    end
    wr(5'h08, 8'h40);
    acc(1'b0, 5'h18, 8'h00);
    c = q;
    pm.drive(1'b1, 1'b1, 0);
    repeat (6) @(posedge mclk_in);
    acc(1'b0, 5'h18, 8'h00);
    `CHK(q != c, 1'b1)
  endtask
  task automatic t_pwm;
    int dn;
    bit hi, lo;
    for (int i = 0; i < 8; i++) begin
      wr(5'h00, 8'h00);
      wr(5'h04, {3'h4, i[2:0], 2'h0});
      wr(5'h08, {3'h4, i[2:0], 2'h0});
      wr(5'h00, 8'h09);
      repeat (3) @(posedge mclk_in);
      `CHK({pa, pb}, {2{(i[2] ~^ i[1]) ^ i[0]}})
    end
    for (int j = 0; j < 4; j++) begin
      wr(5'h00, 8'h00);
      wr(5'h04, 8'hA8);
      wr(5'h08, {6'h2A, j[1:0]});
      wr(5'h00, 8'h09);
      dn = 0;
      hi = 0;
      lo = 0;
      repeat (100) begin
        acc(1'b0, 5'h04, 8'h00);
        if (q[1]) dn++;
        hi |= pb;
        lo |= !pb;
      end
      `CHK({dn > 0, hi, lo}, {j != 0, 2'b11})
    end
    wr(5'h00, 8'h00);
    wr(5'h04, 8'hB8);
    wr(5'h00, 8'h09);
    repeat (3) @(posedge mclk_in);
    `CHK(pa, 1'b1)
    repeat (60) @(posedge mclk_in);
    `CHK(pa, 1'b0)
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    arst_n_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h0;
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(posedge mclk_in);
    t_regs;
    wr(5'h0C, 8'h28);
    wr(5'h10, 8'h50);
    t_cmp(8'h18, 1'b1, 1'b0);
    t_cmp(8'h3C, 1'b0, 1'b1);
    t_cmp(8'h28, 1'b1, 1'b1);
    t_cmp(8'h04, 1'b1, 1'b1);
    t_clr;
    t_cap;
    t_pwm;
    stop_test;
  end
  // Roughly five times the expected run
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    stop_test;
  end
endmodule // tb
bind etc_timer etc_timer_monitor #(.CNT_W(CNT_W)) mon (.mclk_in, .arst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .channel_a_output_pin_out,
  .channel_a_output_pin_oe_n_out, .channel_b_output_pin_out, .channel_b_output_pin_oe_n_out);
